/* File: core/srs_sequencer.sv */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Bus clock runs at half the selected clock-generator output rate.
// - Bus frequency is reference clock or PLL clock divided by four.
// - Power-on or brown-out: clocks held, pin low 4096 cycles, then clocks start.
// - Stop exit waits 4096 or 32 reference cycles before clocks run.
// - Wait mode stops CPU clock; enabled peripherals keep clocking.
// - Every reset gives the normal or monitor vector and asserts internal reset.
// - Internal reset returns registers and modules to defaults; here the option register keeps its value.
// - Internal reset clears stabilisation counter; external reset leaves it.
// - Each reset source sets its own cause flag.
// - Outside low on reset pin halts device; flag only if long enough.
// - Internal sources drive pin low 32 cycles, then reset 32 more.
// - Power-on and brown-out drive pin low 4096 cycles before release sequence.
// - Watchdog reset accepted asynchronously to bus clock.
// - Recovery takes 4163 cycles for power/brown-out, 67 for others.
// - Power-on: pin low 4096 cycles, CPU released 64 cycles later.
// - Power-on pulse asserts reset, enables generator output, sets power flag.
// - Watchdog overflow resets and flags only while watchdog disable is zero.
// - Stabilisation counter is twelve bits, advanced by reference clock.
// - Short stop recovery bit shortens stop delay to 32 cycles.
// - Illegal opcode sets its flag and resets.
// - Only opcode fetch from unmapped address resets; data access does not.
module srs_sequencer
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire srs_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire srs_rst_src_t rst_src,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic pll_select,
  input wire logic pll_output_clock_tick,
  input wire logic monitor_mode,
  input wire logic stop_request,
  input wire logic stop_wake,
  input wire logic wait_mode,
  input wire logic break_wait_event,
  output logic internal_reset,
  output logic vector_fetch,
  output logic [15:0] reset_vector,
  output logic clock_generator_output,
  output logic bus_clk_en,
  output logic cpu_clk_en,
  output logic [PERIPH_N-1:0] periph_clk_en,
  output logic break_clear_enable
);

  srs_state_t state;
  srs_state_t next_state;
  logic [11:0] stab_cnt;
  logic [6:0] aux_cnt;
  logic [3:0] low_cnt;
  logic clr_stab;
  logic clr_aux;
  logic [2:0] wdog_sync;
  logic cgm_en;
  logic cgm_phase;
  logic bus_phase;
  logic [7:0] cause;
  logic [7:0] break_state;
  logic [7:0] break_ctrl;
  logic [7:0] option;
  logic [7:0] wait_mask;

  // Clock division: selected source, then /2 for the generator output,
  // then /2 again for the bus, giving /4 overall.
  wire src_tick = pll_select ? pll_output_clock_tick : 1'b1;
  wire cgm_tick = src_tick & cgm_phase & cgm_en;
  wire bus_tick = cgm_tick & bus_phase;

  // Watchdog overflow arrives from another timing domain
  wire wdog_rise = wdog_sync[1] & ~wdog_sync[2];
  wire wdog_go = wdog_rise & ~option[OPT_WDOG_DIS_BIT];
  wire fetch_go = rst_src.opcode_fetch & rst_src.unmapped_access;
  wire opc_go = rst_src.bad_opcode;
  wire power_go = rst_src.power_on_pulse | rst_src.brownout_trip;

  wire in_reset = (state == SRS_POR_HOLD) | (state == SRS_DRIVE) |
                  (state == SRS_IREL) | (state == SRS_EXT_HOLD);
  wire int_go = ~in_reset & (wdog_go | opc_go | fetch_go);
  // The pin is only watched while this end is not pulling it low itself
  wire pin_watch = (state == SRS_RUN) | (state == SRS_VEC) |
                   (state == SRS_STOP) | (state == SRS_STOP_REC);
  wire ext_low = pin_watch & ~rst_pin_in;

  wire [11:0] stop_last = option[OPT_SHORT_STOP_RECOVERY_BIT] ? STAB_SHORT_LAST : STAB_LONG_LAST;

  always_comb begin
    next_state = state;
    clr_stab = 1'b0;
    clr_aux = 1'b0;
    if (power_go) begin
      // Held in place while the power source stays active
      next_state = SRS_POR_HOLD;
      clr_stab = 1'b1;
    end else if (int_go) begin
      next_state = SRS_DRIVE;
      clr_stab = 1'b1;
      clr_aux = 1'b1;
    end else if (ext_low) begin
      next_state = SRS_EXT_HOLD;
    end else begin
      unique case (state)
        SRS_RUN: begin
          if (stop_request) begin
            next_state = SRS_STOP;
            clr_stab = 1'b1;
          end
        end
        SRS_POR_HOLD: begin
          if (stab_cnt == STAB_LONG_LAST) begin
            next_state = SRS_IREL;
            clr_aux = 1'b1;
          end
        end
        SRS_DRIVE: begin
          if (aux_cnt == DRIVE_LAST) begin
            next_state = SRS_IREL;
          end
        end
        SRS_IREL: begin
          if (aux_cnt == IREL_LAST) begin
            next_state = SRS_VEC;
            clr_aux = 1'b1;
          end
        end
        SRS_VEC: begin
          if (aux_cnt == VEC_LAST) begin
            next_state = SRS_RUN;
          end
        end
        SRS_EXT_HOLD: begin
          if (rst_pin_in) begin
            next_state = SRS_IREL;
            clr_aux = 1'b1;
          end
        end
        SRS_STOP: begin
          if (stop_wake) begin
            next_state = SRS_STOP_REC;
            clr_stab = 1'b1;
          end
        end
        SRS_STOP_REC: begin
          if (stab_cnt == stop_last) begin
            next_state = SRS_RUN;
          end
        end
      endcase
    end
  end

  // Cause flags: a new reset sets its bit in the same cycle a read clears
  wire pin_long = (low_cnt >= RST_MIN_CYC);
  wire ext_done = (state == SRS_EXT_HOLD) & rst_pin_in & ~power_go & ~int_go;
  wire [7:0] set_bits = (8'(rst_src.power_on_pulse) << CAUSE_POR_BIT) |
                        (8'(rst_src.brownout_trip) << CAUSE_LVI_BIT) |
                        (8'(int_go & wdog_go) << CAUSE_WDOG_BIT) |
                        (8'(int_go & opc_go) << CAUSE_OPC_BIT) |
                        (8'(int_go & fetch_go) << CAUSE_FETCH_BIT) |
                        (8'(ext_done & pin_long) << CAUSE_PIN_BIT);

  // Register decode
  wire addr_ok = (bus_req.addr[1:0] == 2'b00);
  wire [15:0] idx = bus_req.addr[ADDR_W-1:2];
  wire sel_break = addr_ok & (idx == IDX_BREAK_STATE);
  wire sel_cause = addr_ok & (idx == IDX_RESET_CAUSE);
  wire sel_bctrl = addr_ok & (idx == IDX_BREAK_CTRL);
  wire sel_opt = addr_ok & (idx == IDX_OPTION);
  wire sel_wmask = addr_ok & (idx == IDX_WAIT_MASK);
  wire rd_cause = bus_req.rd & sel_cause;
  wire [7:0] next_cause = rst_src.power_on_pulse ? set_bits :
                          ((rd_cause ? 8'h00 : cause) | set_bits);
  wire [7:0] break_during_wait_flag_mask = 8'(1) << BREAK_DURING_WAIT_FLAG_BIT;
  wire [7:0] bcfe_mask = 8'(1) << BCFE_BIT;
  wire break_during_wait_flag_clr = bus_req.wr & sel_break & ~bus_req.wdata[BREAK_DURING_WAIT_FLAG_BIT];
  wire [7:0] next_break_state = ((break_during_wait_flag_clr ? 8'h00 : break_state) |
                                 (break_wait_event ? break_during_wait_flag_mask : 8'h00)) & break_during_wait_flag_mask;
  wire [7:0] next_rd_data = ~bus_req.rd ? 8'h00 :
                            sel_break ? break_state :
                            sel_cause ? cause :
                            sel_bctrl ? break_ctrl :
                            sel_opt ? option :
                            sel_wmask ? wait_mask : 8'h00;

  // Output terms seen one cycle ahead so every output is a flip-flop
  wire next_internal_reset = (next_state == SRS_POR_HOLD) | (next_state == SRS_DRIVE) |
                   (next_state == SRS_IREL) | (next_state == SRS_EXT_HOLD);
  wire next_pin_oe = (next_state == SRS_POR_HOLD) | (next_state == SRS_DRIVE);
  wire next_held = (next_state == SRS_POR_HOLD) | (next_state == SRS_STOP) |
                   (next_state == SRS_STOP_REC);
  wire next_bus_en = bus_tick & ~next_held;
  wire next_cpu_en = next_bus_en & ~wait_mode;
  logic [PERIPH_N-1:0] next_periph_en;

  genvar gi;
  generate
    for (gi = 0; gi < PERIPH_N; gi++) begin : g_periph
      assign next_periph_en[gi] = next_bus_en & (~wait_mode | wait_mask[gi]);
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SRS_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Free-running twelve-bit counter, stepped every reference cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stab_cnt <= 12'h000;
    end else if (clr_stab) begin
      stab_cnt <= 12'h000;
    end else begin
      stab_cnt <= stab_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_cnt <= 7'h00;
    end else if (clr_aux) begin
      aux_cnt <= 7'h00;
    end else if (aux_cnt != IREL_LAST) begin
      aux_cnt <= aux_cnt + 7'h01;
    end
  end

  // Low-time meter for the pin; saturates so long pulses cannot wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt <= 4'h0;
    end else if (ext_low) begin
      low_cnt <= 4'h1;
    end else if ((state == SRS_EXT_HOLD) && !rst_pin_in && !pin_long) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdog_sync <= 3'b000;
    end else begin
      wdog_sync <= {wdog_sync[1:0], rst_src.watchdog_overflow};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cgm_en <= 1'b0;
      cgm_phase <= 1'b0;
      bus_phase <= 1'b0;
    end else begin
      cgm_en <= cgm_en | (state == SRS_POR_HOLD);
      if (src_tick && cgm_en) begin
        cgm_phase <= ~cgm_phase;
      end
      if (cgm_tick) begin
        bus_phase <= ~bus_phase;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cause <= CAUSE_RESET;
    end else begin
      cause <= next_cause;
    end
  end

  // Option bits survive internal reset so the chosen recovery stays in force
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      option <= OPTION_RESET;
    end else if (bus_req.wr && sel_opt) begin
      option <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      break_state <= BREAK_STATE_RESET;
      break_ctrl <= BREAK_CTRL_RESET;
      wait_mask <= WAIT_MASK_RESET;
    end else if (internal_reset) begin
      break_state <= BREAK_STATE_RESET;
      break_ctrl <= BREAK_CTRL_RESET;
      wait_mask <= WAIT_MASK_RESET;
    end else begin
      break_state <= next_break_state;
      if (bus_req.wr && sel_bctrl) begin
        break_ctrl <= bus_req.wdata & bcfe_mask;
      end
      if (bus_req.wr && sel_wmask) begin
        wait_mask <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
      internal_reset <= 1'b1;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b1;
      vector_fetch <= 1'b0;
      reset_vector <= VECTOR_NORMAL;
      clock_generator_output <= 1'b0;
      bus_clk_en <= 1'b0;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= '0;
      break_clear_enable <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      internal_reset <= next_internal_reset;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= next_pin_oe;
      vector_fetch <= (next_state == SRS_VEC);
      reset_vector <= monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL;
      clock_generator_output <= cgm_tick;
      bus_clk_en <= next_bus_en;
      cpu_clk_en <= next_cpu_en;
      periph_clk_en <= next_periph_en;
      break_clear_enable <= break_ctrl[BCFE_BIT];
    end
  end

endmodule // srs_sequencer

/* File: core/srs_pkg.sv */
package srs_pkg;

  // Reference clock rate, used to turn printed times into cycle counts
  localparam int unsigned REF_CLK_MHZ = 25;
  // Least low time on the reset pin that is recorded as a pin reset
  localparam int unsigned RST_MIN_NS = 200;
  localparam int unsigned RST_MIN_CYC_I = (RST_MIN_NS * REF_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RST_MIN_CYC = 4'(RST_MIN_CYC_I);

  // Last count values of the sequencing phases
  localparam logic [11:0] STAB_LONG_LAST = 12'hFFF;
  localparam logic [11:0] STAB_SHORT_LAST = 12'h01F;
  localparam logic [6:0] DRIVE_LAST = 7'h1F;
  localparam logic [6:0] IREL_LAST = 7'h3F;
  localparam logic [6:0] VEC_LAST = 7'h02;

  localparam logic [15:0] VECTOR_NORMAL = 16'hFFFE;
  localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;

  // Register indices; the byte address is four times the index
  localparam int unsigned ADDR_W = 18;
  localparam logic [15:0] IDX_BREAK_STATE = 16'hFE00;
  localparam logic [15:0] IDX_RESET_CAUSE = 16'hFE01;
  localparam logic [15:0] IDX_BREAK_CTRL = 16'hFE03;
  localparam logic [15:0] IDX_OPTION = 16'hFE04;
  localparam logic [15:0] IDX_WAIT_MASK = 16'hFE05;

  localparam int unsigned CAUSE_POR_BIT = 7;
  localparam int unsigned CAUSE_PIN_BIT = 6;
  localparam int unsigned CAUSE_WDOG_BIT = 5;
  localparam int unsigned CAUSE_OPC_BIT = 4;
  localparam int unsigned CAUSE_FETCH_BIT = 3;
  localparam int unsigned CAUSE_LVI_BIT = 1;
  localparam int unsigned BREAK_DURING_WAIT_FLAG_BIT = 1;
  localparam int unsigned BCFE_BIT = 7;
  localparam int unsigned OPT_WDOG_DIS_BIT = 0;
  localparam int unsigned OPT_SHORT_STOP_RECOVERY_BIT = 1;

  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [7:0] BREAK_STATE_RESET = 8'h00;
  localparam logic [7:0] BREAK_CTRL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] WAIT_MASK_RESET = 8'h00;

  localparam int unsigned PERIPH_N = 8;

  typedef enum logic [2:0] {
    SRS_RUN      = 3'b000,
    SRS_POR_HOLD = 3'b001,
    SRS_DRIVE    = 3'b010,
    SRS_IREL     = 3'b011,
    SRS_VEC      = 3'b100,
    SRS_EXT_HOLD = 3'b101,
    SRS_STOP     = 3'b110,
    SRS_STOP_REC = 3'b111
  } srs_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } srs_bus_req_t;

  typedef struct packed {
    logic power_on_pulse;
    logic brownout_trip;
    logic watchdog_overflow;
    logic bad_opcode;
    logic opcode_fetch;
    logic unmapped_access;
  } srs_rst_src_t;

endpackage

/* File: verification/srs_pin_peer.sv */
`timescale 1ns/1ns
// Outside chip on the shared reset pin; the pin has a pull-up, so it reads high unless someone pulls it
module srs_pin_peer (
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic pull_low,
  output logic pin_level
);
  assign pin_level = !(pull_low || (rst_pin_oe && !rst_pin_out));
endmodule // srs_pin_peer

/* File: verification/srs_sequencer_props.sv */
`timescale 1ns/1ns
module srs_sequencer_props
  import srs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire srs_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire srs_rst_src_t rst_src,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic monitor_mode,
  input wire logic wait_mode,
  input wire logic internal_reset,
  input wire logic vector_fetch,
  input wire logic [15:0] reset_vector,
  input wire logic clock_generator_output,
  input wire logic bus_clk_en,
  input wire logic cpu_clk_en
);
  // Phase lengths and the kind of reset that started them; counts lag the outputs by one sample
  logic [12:0] oe_cnt;
  logic [12:0] ir_cnt;
  logic arst_seen;
  logic src_seen;
  logic ext_seen;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_cnt <= 13'h0000;
      ir_cnt <= 13'h0000;
      arst_seen <= 1'b1;
      src_seen <= 1'b0;
      ext_seen <= 1'b0;
    end else begin
      oe_cnt <= rst_pin_oe ? oe_cnt + 13'h0001 : 13'h0000;
      ir_cnt <= internal_reset ? ir_cnt + 13'h0001 : 13'h0000;
      arst_seen <= arst_seen && internal_reset;
      src_seen <= rst_src.power_on_pulse || rst_src.brownout_trip || (src_seen && internal_reset);
      ext_seen <= (!rst_pin_in && !rst_pin_oe) || (ext_seen && internal_reset);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_POR_DRIVE: assert property ($fell(rst_pin_oe) && arst_seen && !src_seen |-> oe_cnt == 13'h1000)
    else $error("power-up pin drive length wrong");
  AST_POR_IREL: assert property ($fell(internal_reset) && arst_seen && !src_seen |-> ir_cnt == 13'h1040)
    else $error("power-up reset length wrong");
  AST_INT_DRIVE: assert property ($fell(rst_pin_oe) && !arst_seen && !src_seen |-> oe_cnt == 13'h0020)
    else $error("internal reset pin drive length wrong");
  AST_INT_IREL: assert property ($fell(internal_reset) && !arst_seen && !src_seen && !ext_seen |->
    ir_cnt == 13'h0040)
    else $error("internal reset length wrong");
  AST_VEC3: assert property ($fell(internal_reset) |-> vector_fetch [*3] ##1 !vector_fetch)
    else $error("vector fetch phase not three cycles");
  AST_VEC_ADDR: assert property ($fell(internal_reset) |->
    reset_vector == (monitor_mode ? VECTOR_MONITOR : VECTOR_NORMAL))
    else $error("reset vector wrong");
  AST_HOLD: assert property (rst_pin_oe && (arst_seen || src_seen) |-> !bus_clk_en && !cpu_clk_en)
    else $error("clocks running during reset");
  AST_BUS4: assert property (bus_clk_en |=> !bus_clk_en [*3])
    else $error("bus clock faster than a quarter");
  AST_CGO2: assert property (clock_generator_output |=> !clock_generator_output)
    else $error("generator output faster than a half");
  AST_WAIT: assert property (wait_mode && $past(wait_mode) |-> !cpu_clk_en)
    else $error("cpu clock in wait");
  AST_PIN_LOW: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("pin driven high");
  AST_RD0: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data outside its cycle");
  cover property ($fell(internal_reset) && ext_seen);
  cover property ($fell(internal_reset) && src_seen);
  cover property (wait_mode && bus_clk_en);
endmodule // srs_sequencer_props
bind srs_sequencer srs_sequencer_props u_props (.clk(clk), .arst_n(arst_n), .bus_req(bus_req),
  .rd_data(rd_data), .rst_src(rst_src), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
  .rst_pin_oe(rst_pin_oe), .monitor_mode(monitor_mode), .wait_mode(wait_mode),
  .internal_reset(internal_reset), .vector_fetch(vector_fetch), .reset_vector(reset_vector),
  .clock_generator_output(clock_generator_output), .bus_clk_en(bus_clk_en), .cpu_clk_en(cpu_clk_en));

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb
  import srs_pkg::*;
;
  logic clk, arst_n, pin_level, pin_out, pin_oe, pull_low, pll_select, pll_tick, monitor_mode;
  logic stop_request, stop_wake, wait_mode, brk, ir, vf, cgo, bce, cce, bcf;
  srs_bus_req_t req;
  srs_rst_src_t src;
  logic [7:0] rd_data;
  logic [15:0] vec;
  logic [PERIPH_N-1:0] pce;
  int errors, checked, n, a, b, c, d, e;
  srs_rst_src_t codes [5] = '{6'h08, 6'h04, 6'h03, 6'h10, 6'h20};
  logic [7:0] flags [5] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h80};
  srs_sequencer uut (.clk(clk), .arst_n(arst_n), .bus_req(req), .rd_data(rd_data), .rst_src(src),
    .rst_pin_in(pin_level), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .pll_select(pll_select),
    .pll_output_clock_tick(pll_tick), .monitor_mode(monitor_mode), .stop_request(stop_request),
    .stop_wake(stop_wake), .wait_mode(wait_mode), .break_wait_event(brk), .internal_reset(ir),
    .vector_fetch(vf), .reset_vector(vec), .clock_generator_output(cgo), .bus_clk_en(bce),
    .cpu_clk_en(cce), .periph_clk_en(pce), .break_clear_enable(bcf));
  srs_pin_peer peer (.rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .pull_low(pull_low), .pin_level(pin_level));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // PLL edges at half the reference rate
  always @(posedge clk) pll_tick <= ~pll_tick;
  task print_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] dat);
    @(posedge clk);
    req <= '{addr: {idx, 2'b00}, wdata: dat, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [15:0] idx, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: {idx, 2'b00}, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk({8'h00, rd_data}, {8'h00, exp});
  endtask
  task pulse_src(input srs_rst_src_t v, input int len);
    @(posedge clk);
    src <= v;
    repeat (len) @(posedge clk);
    src <= '0;
  endtask
  // Counts the cycles that internal reset stays high, then lets the vector phase finish
  task run_rst(output int cyc);
    int k;
    #1;
    k = 0;
    cyc = 0;
    while (ir !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    while (ir === 1'b1 && cyc < 9000) begin
      @(posedge clk);
      #1 cyc++;
    end
    repeat (4) @(posedge clk);
  endtask
  task cnt(output int nb, output int ng, output int nc, output int p0, output int p1);
    {nb, ng, nc, p0, p1} = '0;
    repeat (64) begin
      @(posedge clk);
      #1 nb += int'(bce === 1'b1);
      ng += int'(cgo === 1'b1);
      nc += int'(cce === 1'b1);
      p0 += int'(pce[0] === 1'b1);
      p1 += int'(pce[1] === 1'b1);
    end
    @(posedge clk);
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    {arst_n, pull_low, pll_select, pll_tick, monitor_mode, stop_request, stop_wake, wait_mode, brk} = '0;
    req = '0;
    src = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    run_rst(n);
    chk(16'(n), 16'h1040);
    chk(vec, VECTOR_NORMAL);
    rd(IDX_RESET_CAUSE, CAUSE_RESET);
    rd(IDX_RESET_CAUSE, 8'h00);
    rd(IDX_BREAK_STATE, 8'h00);
    rd(16'hFE02, 8'h00);
    @(posedge clk);
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    rd(IDX_BREAK_STATE, 8'h02);
    wr(IDX_BREAK_STATE, 8'h00);
    rd(IDX_BREAK_STATE, 8'h00);
    wr(IDX_RESET_CAUSE, 8'hFF);
    rd(IDX_RESET_CAUSE, 8'h00);
    cnt(a, b, c, d, e);
    chk(16'(a), 16'h0010);
    chk(16'(b), 16'h0020);
    chk(16'(c + d + e), 16'h0030);
    wr(IDX_WAIT_MASK, 8'h01);
    wait_mode <= 1'b1;
    cnt(a, b, c, d, e);
    chk(16'(c), 16'h0000);
    chk(16'(d + e), 16'h0010);
    wait_mode <= 1'b0;
    pll_select <= 1'b1;
    repeat (8) @(posedge clk);
    cnt(a, b, c, d, e);
    chk(16'(a), 16'h0008);
    chk(16'(b), 16'h0010);
    pll_select <= 1'b0;
    monitor_mode <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(IDX_BREAK_CTRL, 8'h80);
      @(posedge clk);
      #1 chk(16'(bcf), 16'h0001);
      pulse_src(codes[i], 1);
      run_rst(n);
      if (i < 3) chk(16'(n), 16'h0040);
      chk(vec, VECTOR_MONITOR);
      rd(IDX_RESET_CAUSE, flags[i]);
      rd(IDX_BREAK_CTRL, 8'h00);
    end
    @(posedge clk);
    monitor_mode <= 1'b0;
    wr(IDX_OPTION, 8'h01);
    pulse_src(6'h08, 2);
    pulse_src(6'h01, 1);
    pulse_src(6'h02, 1);
    repeat (8) @(posedge clk);
    #1 chk(16'(ir), 16'h0000);
    rd(IDX_RESET_CAUSE, 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pull_low <= 1'b1;
      repeat (i == 0 ? 10 : 3) @(posedge clk);
      pull_low <= 1'b0;
      run_rst(n);
      rd(IDX_RESET_CAUSE, i == 0 ? 8'h40 : 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      wr(IDX_OPTION, i == 0 ? 8'h02 : 8'h00);
      stop_request <= 1'b1;
      @(posedge clk);
      stop_request <= 1'b0;
      repeat (4) @(posedge clk);
      stop_wake <= 1'b1;
      @(posedge clk);
      stop_wake <= 1'b0;
      #1 n = 0;
      e = i == 0 ? 32 : 4096;
      while (bce !== 1'b1 && n < 5000) begin
        @(posedge clk);
        #1 n++;
      end
      chk(16'(n >= e && n < e + 8), 16'h0001);
    end
    print_verdict();
  end
endmodule // tb
